// *** psp_pkg.sv ***
`default_nettype none
package psp_pkg;
    localparam int DATA_W = 8;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] PORT_E_INPUTS = 3'h7;
    localparam logic [2:0] ANALOG_ALL_DIGITAL = 3'h7;

    typedef enum logic [1:0] {
        PSP_IDLE  = 2'b00,
        PSP_WRITE = 2'b01,
        PSP_READ  = 2'b10,
        PSP_WAIT  = 2'b11
    } psp_state_t;
endpackage : psp_pkg
`default_nettype wire

// *** psp_parallel_slave_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module psp_parallel_slave_port (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       slave_port_mode_bit,
    input  wire logic [2:0] port_e_direction,
    input  wire logic [2:0] analog_pin_config,
    input  wire logic [7:0] port_d_direction,
    input  wire logic [7:0] portOut,
    input  wire logic       portE0In,
    input  wire logic       portE1In,
    input  wire logic       portE2In,
    input  wire logic [7:0] dataPinIn,
    output logic      [7:0] dataPinOut,
    output logic      [7:0] dataPinOe,
    input  wire logic       fwWrite,
    input  wire logic [7:0] fwWriteData,
    input  wire logic       fwRead,
    output logic      [7:0] fwReadData,
    input  wire logic       fwClearOverflow,
    input  wire logic       fwClearIrq,
    input  wire logic       port_irq_enable,
    output logic            input_full_flag,
    output logic            output_full_flag,
    output logic            input_overflow_flag,
    output logic            port_irq_flag,
    output logic            irqRequest
);
    logic [2:0]          syncA_ff;
    logic [2:0]          syncB_ff;
    logic [7:0]          dataA_ff;
    logic [7:0]          dataB_ff;
    logic [1:0]          phase_ff;
    logic [1:0]          nxt_phase;
    psp_pkg::psp_state_t state_ff;
    psp_pkg::psp_state_t nxt_state;
    logic                seenQ2_ff;
    logic                nxt_seenQ2;
    logic                wasWrite_ff;
    logic                nxt_wasWrite;
    logic [7:0]          outLatch_ff;
    logic [7:0]          nxt_outLatch;
    logic [7:0]          inLatch_ff;
    logic [7:0]          nxt_inLatch;
    logic                inFull_ff;
    logic                nxt_inFull;
    logic                outFull_ff;
    logic                nxt_outFull;
    logic                ovf_ff;
    logic                nxt_ovf;
    logic                pif_ff;
    logic                nxt_pif;
    logic [7:0]          dOut_ff;
    logic [7:0]          nxt_dOut;
    logic [7:0]          dOe_ff;
    logic [7:0]          nxt_dOe;
    logic                irq_ff;
    logic                nxt_irq;
    logic                rdN;
    logic                wrN;
    logic                csN;
    logic                portActive;
    logic                writeLow;
    logic                readLow;
    logic                complete;

    // Strobe pins are asynchronous; two flops each before any use.
    // The data byte travels through the same two stages, so the byte kept is the one seen with the strobes
    // still low and the host need not hold its data past the strobe release.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            syncA_ff <= 3'h7;
            syncB_ff <= 3'h7;
            dataA_ff <= psp_pkg::DATA_RESET;
            dataB_ff <= psp_pkg::DATA_RESET;
        end else begin
            syncA_ff <= {portE2In, portE1In, portE0In};
            syncB_ff <= syncA_ff;
            dataA_ff <= dataPinIn;
            dataB_ff <= dataA_ff;
        end
    end

    // Strobes only count when the pins are digital inputs.
    always_comb begin
        portActive = slave_port_mode_bit
                     && (port_e_direction == psp_pkg::PORT_E_INPUTS)
                     && (analog_pin_config == psp_pkg::ANALOG_ALL_DIGITAL);
        rdN = syncB_ff[0];
        wrN = syncB_ff[1];
        csN = syncB_ff[2];
        writeLow = portActive && !csN && !wrN;
        readLow = portActive && !csN && !rdN;
        nxt_phase = phase_ff + 2'h1;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_seenQ2 = seenQ2_ff;
        nxt_wasWrite = wasWrite_ff;
        nxt_inLatch = inLatch_ff;
        complete = 1'b0;
        case (state_ff)
            psp_pkg::PSP_IDLE: begin
                if (writeLow) begin
                    nxt_state = psp_pkg::PSP_WRITE;
                end else if (readLow) begin
                    nxt_state = psp_pkg::PSP_READ;
                end
            end
            psp_pkg::PSP_WRITE: begin
                if (writeLow) begin
                    nxt_inLatch = dataB_ff;
                end
                if (!writeLow) begin
                    nxt_state = psp_pkg::PSP_WAIT;
                    nxt_seenQ2 = 1'b0;
                    nxt_wasWrite = 1'b1;
                end
            end
            psp_pkg::PSP_READ: begin
                if (!readLow) begin
                    nxt_state = psp_pkg::PSP_WAIT;
                    nxt_seenQ2 = 1'b0;
                    nxt_wasWrite = 1'b0;
                end
            end
            psp_pkg::PSP_WAIT: begin
                if (phase_ff == psp_pkg::PHASE_Q2) begin
                    nxt_seenQ2 = 1'b1;
                end
                if (seenQ2_ff && phase_ff == psp_pkg::PHASE_Q4) begin
                    complete = 1'b1;
                    nxt_state = psp_pkg::PSP_IDLE;
                end
            end
            default: begin
                nxt_state = psp_pkg::PSP_IDLE;
            end
        endcase
        if (!portActive) begin
            nxt_state = psp_pkg::PSP_IDLE;
        end
    end

    // Flag updates; hardware sets win over firmware clears.
    always_comb begin
        nxt_outLatch = fwWrite ? fwWriteData : outLatch_ff;
        nxt_inFull = inFull_ff;
        nxt_outFull = outFull_ff;
        nxt_ovf = ovf_ff;
        nxt_pif = pif_ff;
        if (fwRead) begin
            nxt_inFull = 1'b0;
        end
        if (fwWrite) begin
            nxt_outFull = 1'b1;
        end
        if (state_ff == psp_pkg::PSP_IDLE && readLow && !writeLow) begin
            nxt_outFull = 1'b0;
        end
        if (fwClearOverflow) begin
            nxt_ovf = 1'b0;
        end
        if (state_ff == psp_pkg::PSP_IDLE && writeLow && inFull_ff && !fwRead) begin
            nxt_ovf = 1'b1;
        end
        if (fwClearIrq) begin
            nxt_pif = 1'b0;
        end
        if (complete) begin
            nxt_pif = 1'b1;
            if (wasWrite_ff) begin
                nxt_inFull = 1'b1;
            end
        end
        if (!slave_port_mode_bit) begin
            nxt_inFull = 1'b0;
            nxt_outFull = 1'b0;
        end
        nxt_irq = nxt_pif && port_irq_enable;
        // The direction register is deliberately unused in slave mode.
        nxt_dOe = (readLow && state_ff != psp_pkg::PSP_WRITE) ? 8'hff : 8'h00;
        nxt_dOut = nxt_outLatch;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_ff <= psp_pkg::PHASE_Q1;
            state_ff <= psp_pkg::PSP_IDLE;
            seenQ2_ff <= 1'b0;
            wasWrite_ff <= 1'b0;
            outLatch_ff <= psp_pkg::DATA_RESET;
            inLatch_ff <= psp_pkg::DATA_RESET;
            inFull_ff <= 1'b0;
            outFull_ff <= 1'b0;
            ovf_ff <= 1'b0;
            pif_ff <= 1'b0;
            irq_ff <= 1'b0;
            dOut_ff <= psp_pkg::DATA_RESET;
            dOe_ff <= 8'h00;
        end else begin
            phase_ff <= nxt_phase;
            state_ff <= nxt_state;
            seenQ2_ff <= nxt_seenQ2;
            wasWrite_ff <= nxt_wasWrite;
            outLatch_ff <= nxt_outLatch;
            inLatch_ff <= nxt_inLatch;
            inFull_ff <= nxt_inFull;
            outFull_ff <= nxt_outFull;
            ovf_ff <= nxt_ovf;
            pif_ff <= nxt_pif;
            irq_ff <= nxt_irq;
            dOut_ff <= nxt_dOut;
            dOe_ff <= nxt_dOe;
        end
    end

    always_comb begin
        dataPinOut = dOut_ff;
        dataPinOe = dOe_ff;
        fwReadData = inLatch_ff;
        input_full_flag = inFull_ff;
        output_full_flag = outFull_ff;
        input_overflow_flag = ovf_ff;
        port_irq_flag = pif_ff;
        irqRequest = irq_ff;
    end

    property p_full_clear_by_read;
        @(posedge mclk) disable iff (sys_rst)
        $fell(inFull_ff) |-> ($past(fwRead) || !$past(slave_port_mode_bit));
    endproperty
    a_full_clear_by_read: assert property (p_full_clear_by_read) else $error("input full cleared without read");

    property p_pif_with_full;
        @(posedge mclk) disable iff (sys_rst)
        ($rose(inFull_ff) && $past(slave_port_mode_bit)) |-> pif_ff;
    endproperty
    a_pif_with_full: assert property (p_pif_with_full) else $error("irq flag not set with input full");

    property p_outside_mode;
        @(posedge mclk) disable iff (sys_rst)
        !slave_port_mode_bit |=> (!inFull_ff && !outFull_ff);
    endproperty
    a_outside_mode: assert property (p_outside_mode) else $error("full flags not held clear");

    property p_oe_read;
        @(posedge mclk) disable iff (sys_rst)
        (dOe_ff != 8'h00) |-> $past(readLow);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("data driven outside read");

    property p_irq_gate;
        @(posedge mclk) disable iff (sys_rst)
        irq_ff |-> $past(port_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_out_full_fw;
        @(posedge mclk) disable iff (sys_rst)
        (fwWrite && slave_port_mode_bit) |=> outFull_ff;
    endproperty
    a_out_full_fw: assert property (p_out_full_fw) else $error("output full not set by write");

    property p_overflow_set;
        @(posedge mclk) disable iff (sys_rst)
        ($rose(state_ff == psp_pkg::PSP_WRITE) && $past(inFull_ff) && !$past(fwRead)) |-> ovf_ff;
    endproperty
    a_overflow_set: assert property (p_overflow_set) else $error("second write did not flag overflow");

    property p_read_clears_full;
        @(posedge mclk) disable iff (sys_rst)
        $rose(state_ff == psp_pkg::PSP_READ) |-> !outFull_ff;
    endproperty
    a_read_clears_full: assert property (p_read_clears_full) else $error("read start left output full");

    property p_complete_q4;
        @(posedge mclk) disable iff (sys_rst)
        complete |-> (phase_ff == psp_pkg::PHASE_Q4);
    endproperty
    a_complete_q4: assert property (p_complete_q4) else $error("completion off phase four");

    sequence s_wait_entry;
        state_ff != psp_pkg::PSP_WAIT ##1 state_ff == psp_pkg::PSP_WAIT;
    endsequence

    sequence s_wait_exit;
        ##[1:8] state_ff != psp_pkg::PSP_WAIT;
    endsequence

    property p_wait_bound;
        @(posedge mclk) disable iff (sys_rst)
        s_wait_entry |-> s_wait_exit;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("completion later than eight cycles");
endmodule : psp_parallel_slave_port
`default_nettype wire

// *** psp_ext_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module psp_ext_host (
    input  wire logic       mclk,
    input  wire logic [7:0] dataPinOut,
    input  wire logic [7:0] dataPinOe,
    output logic            readN,
    output logic            writeN,
    output logic            selectN,
    output logic      [7:0] busData
);
    initial begin
        readN = 1'b1;
        writeN = 1'b1;
        selectN = 1'b1;
        busData = 8'h00;
    end

    // Data turns to the inverse of the byte as the strobes rise, as a fast host would leave it.
    task automatic bus_write(input logic [7:0] d, input int hold);
        @(posedge mclk);
        selectN <= 1'b0;
        writeN <= 1'b0;
        busData <= d;
        repeat (hold) @(posedge mclk);
        selectN <= 1'b1;
        writeN <= 1'b1;
        busData <= ~d;
    endtask : bus_write

    task automatic bus_read(input int hold, output logic [7:0] d, output logic [7:0] oe);
        @(posedge mclk);
        selectN <= 1'b0;
        readN <= 1'b0;
        repeat (hold) @(posedge mclk);
        d = dataPinOut;
        oe = dataPinOe;
        selectN <= 1'b1;
        readN <= 1'b1;
    endtask : bus_read
endmodule : psp_ext_host
`default_nettype wire

// *** tb_parallel_slave_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_parallel_slave_port;
    logic       mclk, sys_rst, modeBit, irqEn;
    logic [2:0] dirE, anaCfg;
    logic [7:0] dirD, fwWd, dOut, dOe, rdData, seen, oe, d, w, busData;
    logic [3:0] fwP;
    logic       readN, writeN, selectN, inFull, outFull, ovf, pif, irq;
    wire  [7:0] pinIn;
    int         n_errors, comparisons;

    assign pinIn = (dOe & dOut) | (~dOe & busData);

    psp_ext_host host (.mclk(mclk), .dataPinOut(dOut), .dataPinOe(dOe), .readN(readN),
        .writeN(writeN), .selectN(selectN), .busData(busData));

    psp_parallel_slave_port psp_parallel_slave_port_inst (.mclk(mclk), .sys_rst(sys_rst),
        .slave_port_mode_bit(modeBit), .port_e_direction(dirE), .analog_pin_config(anaCfg),
        .port_d_direction(dirD), .portOut(8'h00), .portE0In(readN), .portE1In(writeN),
        .portE2In(selectN), .dataPinIn(pinIn), .dataPinOut(dOut), .dataPinOe(dOe),
        .fwWrite(fwP[2]), .fwWriteData(fwWd), .fwRead(fwP[3]), .fwReadData(rdData),
        .fwClearOverflow(fwP[1]), .fwClearIrq(fwP[0]), .port_irq_enable(irqEn),
        .input_full_flag(inFull), .output_full_flag(outFull), .input_overflow_flag(ovf),
        .port_irq_flag(pif), .irqRequest(irq));

    function automatic logic exp_req(input logic f, input logic e);
        return f & e;
    endfunction : exp_req

    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // Pulse bits are {read, write, clear overflow, clear irq}.
    task automatic fw(input logic [3:0] p, input logic [7:0] wd);
        @(posedge mclk);
        fwP <= p;
        fwWd <= wd;
        @(posedge mclk);
        fwP <= 4'h0;
    endtask : fw

    task automatic xw(input logic [7:0] v);
        host.bus_write(v, 3);
        repeat (12) @(negedge mclk);
    endtask : xw

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        #100000;
        n_errors++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        modeBit = 1'b1;
        irqEn = 1'b1;
        dirE = 3'h7;
        anaCfg = 3'h7;
        dirD = 8'h00;
        fwP = 4'h0;
        fwWd = 8'h00;
        void'($urandom(56221));
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        check("flags_reset", {inFull, outFull, ovf, pif, irq}, 8'h00);
        check("oe_reset", dOe, 8'h00);
        repeat (6) begin
            d = 8'($urandom);
            w = 8'($urandom);
            @(posedge mclk);
            irqEn <= 1'($urandom);
            dirD <= 8'($urandom);
            host.bus_write(d, 3 + $urandom % 4);
            repeat (16) if (inFull !== 1'b1) @(negedge mclk);
            check("full_with_irq", {inFull, pif}, 8'h03);
            @(negedge mclk);
            check("inbound", rdData, d);
            check("irq_req", irq, exp_req(1'b1, irqEn));
            xw(~d);
            check("overflow", ovf, 8'h01);
            fw(4'h8, 8'h00);
            @(negedge mclk);
            check("read_clears_full", {inFull, pif, ovf}, 8'h03);
            fw(4'h3, 8'h00);
            @(negedge mclk);
            check("cleared", {ovf, pif}, 8'h00);
            fw(4'h4, w);
            @(negedge mclk);
            check("out_full_set", outFull, 8'h01);
            host.bus_read(4 + $urandom % 3, seen, oe);
            check("oe_read", oe, 8'hff);
            check("read_data", seen, w);
            @(negedge mclk);
            check("out_full_clear", outFull, 8'h00);
            repeat (12) @(negedge mclk);
            check("read_done", {outFull, pif}, 8'h01);
            check("oe_off", dOe, 8'h00);
            fw(4'h1, 8'h00);
        end
        xw(8'h5a);
        xw(8'ha5);
        fw(4'h4, 8'h3c);
        @(posedge mclk);
        modeBit <= 1'b0;
        repeat (3) @(negedge mclk);
        check("mode_off", {inFull, outFull, ovf}, 8'h01);
        xw(8'h77);
        check("mode_off_write", inFull, 8'h00);
        check("mode_off_data", rdData, 8'ha5);
        // Each bad setting alone must keep the strobes dead.
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            modeBit <= 1'b1;
            dirE <= k ? 3'h7 : 3'h3;
            anaCfg <= k ? 3'h6 : 3'h7;
            fw(4'hb, 8'h00);
            xw(8'h11);
            check("refused", {inFull, pif}, 8'h00);
        end
        close_out();
    end
endmodule : tb_parallel_slave_port
`default_nettype wire
